// ---- arcb_pkg.sv ----
/*
  register offsets, field positions, reset values and decode codes of the
  upper converter configuration bank.
  assumes a host-side serial engine that turns frames into address/data strobes.
*/
package arcb_pkg;
  // ****************************************
  // address map
  // ****************************************
  localparam int ADDR_W = 13;
  localparam logic [12:0] OFF_REF_RANGE = 13'h0018;
  localparam logic [12:0] OFF_PAT1_LO = 13'h0019;
  localparam logic [12:0] OFF_PAT1_HI = 13'h001a;
  localparam logic [12:0] OFF_PAT2_LO = 13'h001b;
  localparam logic [12:0] OFF_PAT2_HI = 13'h001c;
  localparam logic [12:0] OFF_SIG_LO = 13'h0024;
  localparam logic [12:0] OFF_SIG_HI = 13'h0025;
  localparam logic [12:0] OFF_OVR_CTL = 13'h002a;
  localparam logic [12:0] OFF_OUT_ASSIGN = 13'h002e;
  localparam logic [12:0] OFF_SYNC_CTL = 13'h003a;
  localparam logic [12:0] OFF_TRANSFER = 13'h00ff;
  localparam logic [12:0] OFF_RATE_OVR = 13'h0100;
  localparam logic [12:0] OFF_PIN_CTL2 = 13'h0101;
  localparam logic [12:0] OFF_PIN_CTL3 = 13'h0102;
  // ****************************************
  // reset values
  // ****************************************
  localparam logic [7:0] RST_REF_RANGE = 8'h04;
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_SIG = 8'hff;
  localparam logic [7:0] RST_OVR_CTL = 8'h01;
  // ****************************************
  // field masks and positions
  // ****************************************
  localparam logic [7:0] MASK_REF_RANGE = 8'h07;
  localparam logic [7:0] MASK_OVR_CTL = 8'h01;
  localparam logic [7:0] MASK_OUT_ASSIGN = 8'h01;
  localparam logic [7:0] MASK_SYNC_CTL = 8'h06;
  localparam logic [7:0] MASK_RATE_OVR = 8'h7f;
  localparam logic [7:0] MASK_PIN_CTL2 = 8'h81;
  localparam logic [7:0] MASK_PIN_CTL3 = 8'h08;
  localparam int OVR_EN_BIT = 0;
  localparam int SYNC_NEXT_BIT = 2;
  localparam int SYNC_EN_BIT = 1;
  localparam int XFER_BIT = 0;
  localparam int OVRD_EN_BIT = 6;
  localparam int RES_LSB = 3;
  localparam int RATE_LSB = 0;
  localparam int OEB_EN_BIT = 7;
  localparam int SDIO_PD_BIT = 0;
  localparam int CM_PWDN_BIT = 3;
  // ****************************************
  // override decode
  // ****************************************
  localparam logic [2:0] RES_CODE_14 = 3'h2;
  localparam logic [2:0] RES_CODE_12 = 3'h4;
  localparam logic [2:0] RES_CODE_10 = 3'h6;
  localparam logic [4:0] RES_BITS_14 = 5'h0e;
  localparam logic [4:0] RES_BITS_12 = 5'h0c;
  localparam logic [4:0] RES_BITS_10 = 5'h0a;
  localparam logic [2:0] RATE_CODE_80 = 3'h3;
  localparam logic [2:0] RATE_CODE_105 = 3'h4;
  localparam logic [2:0] RATE_CODE_125 = 3'h5;
  localparam logic [7:0] RATE_MSPS_80 = 8'h50;
  localparam logic [7:0] RATE_MSPS_105 = 8'h69;
  localparam logic [7:0] RATE_MSPS_125 = 8'h7d;
  localparam logic [4:0] DEFAULT_RES_BITS = 5'h0e;
  localparam logic [7:0] DEFAULT_MSPS = 8'h7d;
endpackage

// ---- arcb_sync_gate.sv ----
/*
  clock-divider sync gate: passes sync pulses under the enable bits.
  assumes sync_pulse is a one-cycle pulse synchronous to clk_sys.
*/
`timescale 1ns/1ns
module arcb_sync_gate
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic sync_en,
  input wire logic next_only,
  input wire logic sync_pulse,
  output logic div_sync,
  output logic en_clear
);
  logic fire;

  // pending clear blocks a second pass in next-only mode
  assign fire = sync_pulse && sync_en && !en_clear;

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      div_sync <= 1'b0;
      en_clear <= 1'b0;
    end
    else
    begin
      div_sync <= fire;
      en_clear <= fire && next_only;
    end
  end

  property p_gate_pass;
    @(posedge clk_sys) disable iff (!rst_n)
    div_sync |-> $past(sync_pulse) && $past(sync_en);
  endproperty
  a_gate_pass: assert property (p_gate_pass) else $error("sync passed while disabled");

  property p_next_once;
    @(posedge clk_sys) disable iff (!rst_n)
    (sync_pulse && sync_en && !en_clear && next_only) |=> en_clear ##1 !div_sync;
  endproperty
  a_next_once: assert property (p_next_once) else $error("next-only sync not single");
endmodule

// ---- arcb_cfg_bank.sv ----
/*
  upper configuration register bank: pattern, signature, overrange, sync,
  override and pin-control registers with their side effects.
  assumes the serial engine gives one-cycle read/write strobes on clk_sys.
*/
`timescale 1ns/1ns
module arcb_cfg_bank
  import arcb_pkg::*;
(
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic cfg_wr,
  input wire logic cfg_rd,
  input wire logic [arcb_pkg::ADDR_W-1:0] cfg_addr,
  input wire logic [7:0] cfg_wdata,
  output logic [7:0] cfg_rdata_r,
  output logic cfg_rvalid_r,
  input wire logic sig_load,
  input wire logic [15:0] sig_value,
  input wire logic ovr_in,
  output logic ovr_out_r,
  output logic ovr_oe_r,
  input wire logic sync_pulse,
  output logic div_sync_r,
  output logic [2:0] ref_range_r,
  output logic [15:0] user_pat1_r,
  output logic [15:0] user_pat2_r,
  output logic out_assign_r,
  output logic [4:0] res_bits_r,
  output logic [7:0] rate_msps_r,
  output logic chip_pwdn_r,
  output logic oeb_pin_en_r,
  output logic sdio_pd_dis_r,
  output logic cm_pwdn_r
);
  import arcb_pkg::*;

  function automatic logic hit(input logic [12:0] a, input logic [12:0] off);
    hit = (a == off);
  endfunction

  // ****************************************
  // reset release
  // ****************************************
  logic rst_meta_r;
  logic rst_n;
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rst_meta_r <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_meta_r <= 1'b1;
      rst_n <= rst_meta_r;
    end
  end

  // ****************************************
  // register storage
  // ****************************************
  logic [7:0] ref_r, p1l_r, p1h_r, p2l_r, p2h_r, ovr_ctl_r, assign_r, sync_r, rovr_r, pc2_r, pc3_r;
  logic [15:0] sig_r;
  logic [7:0] app_r;
  logic sync_clear;
  logic xfer_wr;

  assign xfer_wr = cfg_wr && hit(cfg_addr, OFF_TRANSFER) && cfg_wdata[XFER_BIT];

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ref_r <= RST_REF_RANGE;
      p1l_r <= RST_ZERO;
      p1h_r <= RST_ZERO;
      p2l_r <= RST_ZERO;
      p2h_r <= RST_ZERO;
      ovr_ctl_r <= RST_OVR_CTL;
      assign_r <= RST_ZERO;
      rovr_r <= RST_ZERO;
      pc2_r <= RST_ZERO;
      pc3_r <= RST_ZERO;
    end
    else if (cfg_wr)
    begin
      // writes take effect at once, except the rate override, which is applied on transfer
      if (hit(cfg_addr, OFF_REF_RANGE)) ref_r <= cfg_wdata & MASK_REF_RANGE;
      if (hit(cfg_addr, OFF_PAT1_LO)) p1l_r <= cfg_wdata;
      if (hit(cfg_addr, OFF_PAT1_HI)) p1h_r <= cfg_wdata;
      if (hit(cfg_addr, OFF_PAT2_LO)) p2l_r <= cfg_wdata;
      if (hit(cfg_addr, OFF_PAT2_HI)) p2h_r <= cfg_wdata;
      if (hit(cfg_addr, OFF_OVR_CTL)) ovr_ctl_r <= cfg_wdata & MASK_OVR_CTL;
      if (hit(cfg_addr, OFF_OUT_ASSIGN)) assign_r <= cfg_wdata & MASK_OUT_ASSIGN;
      if (hit(cfg_addr, OFF_RATE_OVR)) rovr_r <= cfg_wdata & MASK_RATE_OVR;
      if (hit(cfg_addr, OFF_PIN_CTL2)) pc2_r <= cfg_wdata & MASK_PIN_CTL2;
      if (hit(cfg_addr, OFF_PIN_CTL3)) pc3_r <= cfg_wdata & MASK_PIN_CTL3;
    end
  end

  // sync control: host write wins over the self-clear
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      sync_r <= RST_ZERO;
    else if (cfg_wr && hit(cfg_addr, OFF_SYNC_CTL))
      sync_r <= cfg_wdata & MASK_SYNC_CTL;
    else if (sync_clear)
      sync_r[SYNC_EN_BIT] <= 1'b0;
  end

  // signature is loaded only by the datapath
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      sig_r <= {RST_SIG, RST_SIG};
    else if (sig_load)
      sig_r <= sig_value;
  end

  // override copy applied on transfer
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      app_r <= RST_ZERO;
    else if (xfer_wr)
      app_r <= rovr_r;
  end

  // ****************************************
  // sync gate
  // ****************************************
  arcb_sync_gate u_gate
  (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .sync_en(sync_r[SYNC_EN_BIT]),
    .next_only(sync_r[SYNC_NEXT_BIT]),
    .sync_pulse(sync_pulse),
    .div_sync(div_sync_r),
    .en_clear(sync_clear)
  );

  // ****************************************
  // applied outputs
  // ****************************************
  logic [2:0] app_res;
  logic [2:0] app_rate;
  logic [4:0] res_nxt;
  logic [7:0] rate_nxt;
  assign app_res = app_r[RES_LSB +: 3];
  assign app_rate = app_r[RATE_LSB +: 3];

  always_comb
  begin
    res_nxt = DEFAULT_RES_BITS;
    rate_nxt = DEFAULT_MSPS;
    if (app_r[OVRD_EN_BIT])
    begin
      case (app_res)
        RES_CODE_14: res_nxt = RES_BITS_14;
        RES_CODE_12: res_nxt = RES_BITS_12;
        RES_CODE_10: res_nxt = RES_BITS_10;
        default: res_nxt = DEFAULT_RES_BITS;
      endcase
      case (app_rate)
        RATE_CODE_80: rate_nxt = RATE_MSPS_80;
        RATE_CODE_105: rate_nxt = RATE_MSPS_105;
        RATE_CODE_125: rate_nxt = RATE_MSPS_125;
        default: rate_nxt = DEFAULT_MSPS;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      res_bits_r <= DEFAULT_RES_BITS;
      rate_msps_r <= DEFAULT_MSPS;
      chip_pwdn_r <= 1'b0;
    end
    else
    begin
      res_bits_r <= res_nxt;
      rate_msps_r <= rate_nxt;
      chip_pwdn_r <= rate_nxt > DEFAULT_MSPS;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ovr_out_r <= 1'b0;
      ovr_oe_r <= 1'b0;
    end
    else
    begin
      ovr_out_r <= ovr_in && ovr_ctl_r[OVR_EN_BIT];
      ovr_oe_r <= ovr_ctl_r[OVR_EN_BIT];
    end
  end

  assign ref_range_r = ref_r[2:0];
  assign user_pat1_r = {p1h_r, p1l_r};
  assign user_pat2_r = {p2h_r, p2l_r};
  assign out_assign_r = assign_r[0];
  assign oeb_pin_en_r = pc2_r[OEB_EN_BIT];
  assign sdio_pd_dis_r = pc2_r[SDIO_PD_BIT];
  assign cm_pwdn_r = pc3_r[CM_PWDN_BIT];

  // ****************************************
  // read path
  // ****************************************
  logic [7:0] rd_nxt;
  always_comb
  begin
    rd_nxt = RST_ZERO;
    case (cfg_addr)
      OFF_REF_RANGE: rd_nxt = ref_r;
      OFF_PAT1_LO: rd_nxt = p1l_r;
      OFF_PAT1_HI: rd_nxt = p1h_r;
      OFF_PAT2_LO: rd_nxt = p2l_r;
      OFF_PAT2_HI: rd_nxt = p2h_r;
      OFF_SIG_LO: rd_nxt = sig_r[7:0];
      OFF_SIG_HI: rd_nxt = sig_r[15:8];
      OFF_OVR_CTL: rd_nxt = ovr_ctl_r;
      OFF_OUT_ASSIGN: rd_nxt = assign_r;
      OFF_SYNC_CTL: rd_nxt = sync_r;
      OFF_RATE_OVR: rd_nxt = rovr_r;
      OFF_PIN_CTL2: rd_nxt = pc2_r;
      OFF_PIN_CTL3: rd_nxt = pc3_r;
      default: rd_nxt = RST_ZERO;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cfg_rdata_r <= RST_ZERO;
      cfg_rvalid_r <= 1'b0;
    end
    else
    begin
      cfg_rvalid_r <= cfg_rd;
      if (cfg_rd)
        cfg_rdata_r <= rd_nxt;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  property p_ovr_gate;
    @(posedge clk_sys) disable iff (!rst_n)
    ovr_out_r |-> $past(ovr_ctl_r[OVR_EN_BIT]) && $past(ovr_in);
  endproperty
  a_ovr_gate: assert property (p_ovr_gate) else $error("overrange driven while disabled");

  property p_sync_selfclr;
    @(posedge clk_sys) disable iff (!rst_n)
    (sync_clear && !(cfg_wr && hit(cfg_addr, OFF_SYNC_CTL))) |=> !sync_r[SYNC_EN_BIT];
  endproperty
  a_sync_selfclr: assert property (p_sync_selfclr) else $error("sync enable not cleared");

  property p_sig_ro;
    @(posedge clk_sys) disable iff (!rst_n)
    !sig_load |=> $stable(sig_r);
  endproperty
  a_sig_ro: assert property (p_sig_ro) else $error("signature changed without load");

  property p_res14;
    @(posedge clk_sys) disable iff (!rst_n)
    (app_r[OVRD_EN_BIT] && app_res == RES_CODE_14) |=> res_bits_r == RES_BITS_14;
  endproperty
  a_res14: assert property (p_res14) else $error("resolution 14 decode wrong");

  property p_rate80;
    @(posedge clk_sys) disable iff (!rst_n)
    (app_r[OVRD_EN_BIT] && app_rate == RATE_CODE_80) |=> rate_msps_r == RATE_MSPS_80 && !chip_pwdn_r;
  endproperty
  a_rate80: assert property (p_rate80) else $error("rate 80 decode wrong");

  property p_hold_override;
    @(posedge clk_sys) disable iff (!rst_n)
    !xfer_wr |=> $stable(app_r);
  endproperty
  a_hold_override: assert property (p_hold_override) else $error("override applied without transfer");

  property p_apply_override;
    @(posedge clk_sys) disable iff (!rst_n)
    xfer_wr |=> app_r == $past(rovr_r) ##1 rate_msps_r == rate_nxt;
  endproperty
  a_apply_override: assert property (p_apply_override) else $error("transfer did not apply");

  property p_upgrade_pwdn;
    @(posedge clk_sys) disable iff (!rst_n)
    chip_pwdn_r |-> $past(rate_nxt) > DEFAULT_MSPS;
  endproperty
  a_upgrade_pwdn: assert property (p_upgrade_pwdn) else $error("power-down without upgrade");
endmodule

// ---- arcb_host.sv ----
/*
  host model of the register port: one-byte write and read transfers.
  assumes clk_sys from the bench and a read answer one cycle after the strobe.
*/
`timescale 1ns/1ns
module arcb_host
  import arcb_pkg::*;
(
  input wire logic clk_sys,
  output logic cfg_wr,
  output logic cfg_rd,
  output logic [arcb_pkg::ADDR_W-1:0] cfg_addr,
  output logic [7:0] cfg_wdata,
  input wire logic [7:0] cfg_rdata_r,
  input wire logic cfg_rvalid_r
);
  initial
  begin
    cfg_wr = 1'b0;
    cfg_rd = 1'b0;
    cfg_addr = 13'h0000;
    cfg_wdata = 8'h00;
  end
  // one-cycle write strobe, data scrambled once released
  task automatic wr(input logic [12:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    cfg_wr <= 1'b1;
    cfg_addr <= a;
    cfg_wdata <= d;
    @(posedge clk_sys);
    cfg_wr <= 1'b0;
    cfg_wdata <= ~d;
  endtask
  // one-cycle read strobe, answer taken after the sampling edge
  task automatic rd(input logic [12:0] a, output logic [7:0] d, output logic v);
    @(posedge clk_sys);
    cfg_rd <= 1'b1;
    cfg_addr <= a;
    @(posedge clk_sys);
    cfg_rd <= 1'b0;
    #1;
    d = cfg_rdata_r;
    v = cfg_rvalid_r;
  endtask
endmodule

// ---- tb.sv ----
/*
  self-checking bench of the upper configuration bank.
  assumes the host model drives the register port; bench drives datapath inputs.
*/
`timescale 1ns/1ns
module tb;
  import arcb_pkg::*;
  logic clk_sys, arst_n, cfg_wr, cfg_rd, cfg_rvalid_r, sig_load, ovr_in, ovr_out_r, ovr_oe_r;
  logic sync_pulse, div_sync_r, out_assign_r, chip_pwdn_r, oeb_pin_en_r, sdio_pd_dis_r, cm_pwdn_r;
  logic [12:0] cfg_addr;
  logic [7:0] cfg_wdata, cfg_rdata_r, rate_msps_r;
  logic [15:0] sig_value, user_pat1_r, user_pat2_r;
  logic [2:0] ref_range_r;
  logic [4:0] res_bits_r;
  logic s;
  int bad_count = 0;
  int n_compared = 0;
  logic [12:0] ra [13] = '{OFF_REF_RANGE, OFF_PAT1_LO, OFF_PAT1_HI, OFF_PAT2_LO, OFF_PAT2_HI, OFF_SIG_LO,
    OFF_SIG_HI, OFF_OVR_CTL, OFF_OUT_ASSIGN, OFF_SYNC_CTL, OFF_RATE_OVR, OFF_PIN_CTL2, OFF_PIN_CTL3};
  logic [7:0] rv [13] = '{8'h04, 8'h00, 8'h00, 8'h00, 8'h00, 8'hff, 8'hff, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  logic [7:0] mk [13] = '{8'h07, 8'hff, 8'hff, 8'hff, 8'hff, 8'h00, 8'h00, 8'h01, 8'h01, 8'h06, 8'h7f, 8'h81, 8'h08};
  logic [2:0] rs [3] = '{3'h2, 3'h4, 3'h6};
  logic [2:0] rt [3] = '{3'h3, 3'h4, 3'h5};
  logic [4:0] eb [3] = '{5'h0e, 5'h0c, 5'h0a};
  logic [7:0] em [3] = '{8'h50, 8'h69, 8'h7d};

  arcb_cfg_bank arcb_cfg_bank_i (.clk_sys(clk_sys), .arst_n(arst_n), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd),
    .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_rdata_r(cfg_rdata_r), .cfg_rvalid_r(cfg_rvalid_r),
    .sig_load(sig_load), .sig_value(sig_value), .ovr_in(ovr_in), .ovr_out_r(ovr_out_r), .ovr_oe_r(ovr_oe_r),
    .sync_pulse(sync_pulse), .div_sync_r(div_sync_r), .ref_range_r(ref_range_r), .user_pat1_r(user_pat1_r),
    .user_pat2_r(user_pat2_r), .out_assign_r(out_assign_r), .res_bits_r(res_bits_r), .rate_msps_r(rate_msps_r),
    .chip_pwdn_r(chip_pwdn_r), .oeb_pin_en_r(oeb_pin_en_r), .sdio_pd_dis_r(sdio_pd_dis_r), .cm_pwdn_r(cm_pwdn_r));
  arcb_host arcb_host_i (.clk_sys(clk_sys), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_addr(cfg_addr),
    .cfg_wdata(cfg_wdata), .cfg_rdata_r(cfg_rdata_r), .cfg_rvalid_r(cfg_rvalid_r));

  // ****************************************
  // tasks
  // ****************************************
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic rchk(input logic [12:0] a, input logic [7:0] e);
    logic [7:0] d;
    logic v;
    arcb_host_i.rd(a, d, v);
    chk({7'h00, v, d}, {8'h01, e});
  endtask
  // one-cycle sync pulse, divider pulse looked for over two cycles
  task automatic pulse(output logic seen);
    @(posedge clk_sys);
    sync_pulse <= 1'b1;
    @(posedge clk_sys);
    sync_pulse <= 1'b0;
    seen = 1'b0;
    repeat (2)
    begin
      #1;
      seen = seen | div_sync_r;
      @(posedge clk_sys);
    end
  endtask
  task automatic wrap_up;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  initial
  begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  initial
  begin
    #100000;
    bad_count++;
    wrap_up;
  end

  initial
  begin
    arst_n = 1'b0;
    sig_load = 1'b0;
    sig_value = 16'h0000;
    ovr_in = 1'b0;
    sync_pulse = 1'b0;
    repeat (5) @(posedge clk_sys);
    arst_n <= 1'b1;
    repeat (3) @(posedge clk_sys);
    #1;
    chk({1'b0, ovr_oe_r, res_bits_r, rate_msps_r, chip_pwdn_r}, {2'b01, 5'h0e, 8'h7d, 1'b0});
    for (int i = 0; i < 13; i++)
      rchk(ra[i], rv[i]);
    rchk(13'h0050, 8'h00);
    rchk(OFF_TRANSFER, 8'h00);
    for (int i = 0; i < 13; i++)
      arcb_host_i.wr(ra[i], {ra[i][3:0], 4'hf});
    for (int i = 0; i < 13; i++)
      rchk(ra[i], ({ra[i][3:0], 4'hf} & mk[i]) | (rv[i] & ~mk[i]));
    chk({9'h000, ref_range_r, out_assign_r, oeb_pin_en_r, sdio_pd_dis_r, cm_pwdn_r}, 16'h007b);
    chk(user_pat1_r, 16'haf9f);
    chk(user_pat2_r, 16'hcfbf);
    chk({2'b00, res_bits_r, rate_msps_r, chip_pwdn_r}, {2'b00, 5'h0e, 8'h7d, 1'b0});
    @(posedge clk_sys);
    sig_value <= 16'h1234;
    sig_load <= 1'b1;
    @(posedge clk_sys);
    sig_load <= 1'b0;
    rchk(OFF_SIG_LO, 8'h34);
    rchk(OFF_SIG_HI, 8'h12);
    @(posedge clk_sys);
    ovr_in <= 1'b1;
    arcb_host_i.wr(OFF_OVR_CTL, 8'h01);
    repeat (2) @(posedge clk_sys);
    #1;
    chk({14'h0000, ovr_oe_r, ovr_out_r}, 16'h0003);
    arcb_host_i.wr(OFF_OVR_CTL, 8'h00);
    repeat (2) @(posedge clk_sys);
    #1;
    chk({14'h0000, ovr_oe_r, ovr_out_r}, 16'h0000);
    arcb_host_i.wr(OFF_SYNC_CTL, 8'h02);
    pulse(s);
    chk({15'h0000, s}, 16'h0001);
    pulse(s);
    chk({15'h0000, s}, 16'h0001);
    arcb_host_i.wr(OFF_SYNC_CTL, 8'h00);
    pulse(s);
    chk({15'h0000, s}, 16'h0000);
    arcb_host_i.wr(OFF_SYNC_CTL, 8'h06);
    pulse(s);
    chk({15'h0000, s}, 16'h0001);
    pulse(s);
    chk({15'h0000, s}, 16'h0000);
    rchk(OFF_SYNC_CTL, 8'h04);
    for (int i = 0; i < 3; i++)
    begin
      arcb_host_i.wr(OFF_RATE_OVR, {2'b01, rs[i], rt[i]});
      arcb_host_i.wr(OFF_TRANSFER, 8'h01);
      repeat (2) @(posedge clk_sys);
      #1;
      chk({2'b00, res_bits_r, rate_msps_r, chip_pwdn_r}, {2'b00, eb[i], em[i], 1'b0});
    end
    arcb_host_i.wr(OFF_RATE_OVR, {2'b01, rs[0], rt[0]});
    repeat (3) @(posedge clk_sys);
    #1;
    chk({2'b00, res_bits_r, rate_msps_r, chip_pwdn_r}, {2'b00, eb[2], em[2], 1'b0});
    rchk(OFF_TRANSFER, 8'h00);
    @(posedge clk_sys);
    arst_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    #1;
    chk({1'b0, ovr_oe_r, res_bits_r, rate_msps_r, chip_pwdn_r}, {2'b00, 5'h0e, 8'h7d, 1'b0});
    @(posedge clk_sys);
    arst_n <= 1'b1;
    repeat (3) @(posedge clk_sys);
    #1;
    chk({14'h0000, ovr_oe_r, ovr_out_r}, 16'h0003);
    rchk(OFF_SYNC_CTL, 8'h00);
    rchk(OFF_RATE_OVR, 8'h00);
    arcb_host_i.wr(OFF_RATE_OVR, {2'b00, rs[2], rt[0]});
    arcb_host_i.wr(OFF_TRANSFER, 8'h01);
    repeat (2) @(posedge clk_sys);
    #1;
    chk({2'b00, res_bits_r, rate_msps_r, chip_pwdn_r}, {2'b00, 5'h0e, 8'h7d, 1'b0});
    wrap_up;
  end
endmodule
